// ==== hw/ccr_consts.svh ====
// Constants for the converter chip configuration register group
// Notes on behaviour
// - Addresses or bits outside the three-register map are unsupported; they read 0 and ignore writes.
// - Port configuration resets to 0x18 with bit order in bits 6 and 1 and soft reset in bits 5 and 2.
// - The grade register shows a read-only speed grade in bits 6:4 with the other bits zero.
// - Speed grade codes are 000 for 20, 001 for 40, 010 for 65 and 011 for 80 MSPS.
// - The serial port shifts MSB first after reset until the bit-order flag selects LSB first.
`ifndef CCR_CONSTS_SVH
`define CCR_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCR_ADDR_PORT_CFG   13'h0000
`define CCR_ADDR_CHIP_IDENTIFIER    13'h0001
`define CCR_ADDR_GRADE      13'h0002

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define CCR_CFG_RESET       8'h18
`define CCR_CFG_LSB_HI      6
`define CCR_CFG_LSB_LO      1
`define CCR_CFG_SRST_HI     5
`define CCR_CFG_SRST_LO     2
`define CCR_GRADE_LSB       4
`define CCR_GRADE_W         3

// ----------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------
`define CCR_INSTR_BITS      16
`define CCR_ADDR_W          13
`define CCR_BYTE_BITS       8

`endif

// ==== hw/ccr_pkg.sv ====
// Types for the converter chip configuration register group
package ccr_pkg;

   // Frame phase of the serial control port
   typedef enum logic [1:0] {
      PH_INSTR,
      PH_DATA,
      PH_DONE
   } ccr_phase_e;

   // Speed grade codes
   typedef enum logic [2:0] {
      GRADE_20MSPS = 3'h0,
      GRADE_40MSPS = 3'h1,
      GRADE_65MSPS = 3'h2,
      GRADE_80MSPS = 3'h3
   } ccr_grade_e;

endpackage

// ==== hw/ccr_regs.sv ====
// Serial control port and chip configuration registers
`timescale 1ns/1ps
`include "ccr_consts.svh"

module ccr_regs
   import ccr_pkg::*;
#(
   parameter logic [7:0] CHIP_IDENTIFIER_CODE = 8'hA5,   // Arbitrary value
   parameter ccr_grade_e SPEED_GRADE  = GRADE_80MSPS
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rst_n,
   // Serial control pins
   input  wire logic csb_pin,
   input  wire logic sclk_pin,
   input  wire logic sdio_in,
   output logic      sdio_out,
   output logic      sdio_oe,
   // Configuration state
   output logic      lsb_first,
   output logic      soft_reset_pulse
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] sync1_reg;
   logic [2:0] sync2_reg;
   logic       sclk_prev_reg;
   logic       csb_s;
   logic       sclk_s;
   logic       sdio_s;
   logic       rise;
   logic       fall;

   // Pins are async to clk_sys; SCLK must stay well below 5 MHz
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         // Idle pin levels, so no false edge follows reset
         sync1_reg     <= 3'h1;
         sync2_reg     <= 3'h1;
         sclk_prev_reg <= 1'b0;
      end else begin
         sync1_reg     <= {sdio_in, sclk_pin, csb_pin};
         sync2_reg     <= sync1_reg;
         sclk_prev_reg <= sync2_reg[1];
      end
   end

   assign csb_s  = sync2_reg[0];
   assign sclk_s = sync2_reg[1];
   assign sdio_s = sync2_reg[2];
   assign rise   = !csb_s && sclk_s && !sclk_prev_reg;
   assign fall   = !csb_s && !sclk_s && sclk_prev_reg;

   // ----------------------------------------------------------------
   // Frame state
   // ----------------------------------------------------------------
   ccr_phase_e                    phase_reg;
   logic [3:0]                    bit_cnt_reg;
   logic [`CCR_INSTR_BITS-1:0]    instr_reg;
   logic [`CCR_INSTR_BITS-1:0]    instr_next;
   logic [`CCR_BYTE_BITS-1:0]     rx_reg;
   logic [`CCR_BYTE_BITS-1:0]     rx_next;
   logic [`CCR_BYTE_BITS-1:0]     tx_reg;
   logic [`CCR_ADDR_W-1:0]        addr_reg;
   logic [`CCR_ADDR_W-1:0]        addr_step;
   logic [`CCR_ADDR_W-1:0]        instr_addr;
   logic                          rd_reg;
   logic                          stream_reg;
   logic [1:0]                    left_reg;
   logic                          lsb_first_reg;
   logic                          byte_done;
   logic                          wr_cfg;

   // Bit order applies to instruction and data alike
   assign instr_next = lsb_first_reg
      ? {sdio_s, instr_reg[`CCR_INSTR_BITS-1:1]}
      : {instr_reg[`CCR_INSTR_BITS-2:0], sdio_s};
   assign rx_next = lsb_first_reg
      ? {sdio_s, rx_reg[`CCR_BYTE_BITS-1:1]}
      : {rx_reg[`CCR_BYTE_BITS-2:0], sdio_s};
   assign instr_addr = instr_next[`CCR_ADDR_W-1:0];
   // Streaming walks down in MSB-first order and up in LSB-first order
   assign addr_step  = lsb_first_reg ? addr_reg + 13'h0001
                                     : addr_reg - 13'h0001;
   assign byte_done  = rise && (phase_reg == PH_DATA)
                       && (bit_cnt_reg == 4'h7);
   assign wr_cfg     = byte_done && !rd_reg
                       && (addr_reg == `CCR_ADDR_PORT_CFG);

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   function automatic logic [7:0] read_byte(
      input logic [`CCR_ADDR_W-1:0] a,
      input logic                   lsb
   );
      logic [7:0] v;
      v = 8'h00;
      if (a == `CCR_ADDR_PORT_CFG) begin
         v = `CCR_CFG_RESET;
         v[`CCR_CFG_LSB_HI] = lsb;
         v[`CCR_CFG_LSB_LO] = lsb;
      end else if (a == `CCR_ADDR_CHIP_IDENTIFIER) begin
         v = CHIP_IDENTIFIER_CODE;
      end else if (a == `CCR_ADDR_GRADE) begin
         v[`CCR_GRADE_LSB +: `CCR_GRADE_W] = SPEED_GRADE;
      end else begin
         v = 8'h00;
      end
      return v;
   endfunction

   // ----------------------------------------------------------------
   // Frame sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n || csb_s) begin
         phase_reg   <= PH_INSTR;
         bit_cnt_reg <= 4'h0;
         instr_reg   <= 16'h0000;
         rx_reg      <= 8'h00;
         addr_reg    <= 13'h0000;
         rd_reg      <= 1'b0;
         stream_reg  <= 1'b0;
         left_reg    <= 2'h0;
      end else if (rise) begin
         bit_cnt_reg <= bit_cnt_reg + 4'h1;
         case (phase_reg)
            PH_INSTR: begin
               instr_reg <= instr_next;
               if (bit_cnt_reg == 4'hF) begin
                  phase_reg   <= PH_DATA;
                  bit_cnt_reg <= 4'h0;
                  rd_reg      <= instr_next[15];
                  stream_reg  <= &instr_next[14:13];
                  left_reg    <= instr_next[14:13];
                  addr_reg    <= instr_addr;
               end
            end
            PH_DATA: begin
               rx_reg <= rx_next;
               if (byte_done) begin
                  bit_cnt_reg <= 4'h0;
                  addr_reg    <= addr_step;
                  left_reg    <= left_reg - 2'h1;
                  if (!stream_reg && left_reg == 2'h0) begin
                     phase_reg <= PH_DONE;
                  end
               end
            end
            // Bits past the counted bytes wait here for CSB high
            default: begin
               bit_cnt_reg <= 4'h0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Port configuration register
   // ----------------------------------------------------------------
   logic srst_req;
   logic lsb_req;

   // Either mirrored copy of a flag acts, so both shift orders decode
   assign srst_req = rx_next[`CCR_CFG_SRST_HI] || rx_next[`CCR_CFG_SRST_LO];
   assign lsb_req  = rx_next[`CCR_CFG_LSB_HI] || rx_next[`CCR_CFG_LSB_LO];

   // Soft reset wins over order bits written in the same byte
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         lsb_first_reg    <= 1'b0;
         soft_reset_pulse <= 1'b0;
      end else begin
         soft_reset_pulse <= 1'b0;
         if (wr_cfg) begin
            if (srst_req) begin
               lsb_first_reg    <= 1'b0;
               soft_reset_pulse <= 1'b1;
            end else begin
               lsb_first_reg <= lsb_req;
            end
         end
      end
   end

   assign lsb_first = lsb_first_reg;

   // ----------------------------------------------------------------
   // Readback shifter
   // ----------------------------------------------------------------
   // Driven on falling SCLK so the host samples on the rising edge
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         tx_reg   <= 8'h00;
         sdio_out <= 1'b0;
         sdio_oe  <= 1'b0;
      end else begin
         // Released as soon as the last counted byte has gone out
         sdio_oe <= !csb_s && rd_reg && (phase_reg == PH_DATA);
         // Next byte is fetched at a last rise, ahead of its first fall
         if (rise && phase_reg == PH_INSTR && bit_cnt_reg == 4'hF) begin
            tx_reg <= read_byte(instr_addr, lsb_first_reg);
         end else if (byte_done && rd_reg) begin
            tx_reg <= read_byte(addr_step, lsb_first_reg);
         end else if (fall && rd_reg && phase_reg == PH_DATA) begin
            if (lsb_first_reg) begin
               sdio_out <= tx_reg[0];
               tx_reg   <= {1'b0, tx_reg[7:1]};
            end else begin
               sdio_out <= tx_reg[7];
               tx_reg   <= {tx_reg[6:0], 1'b0};
            end
         end
      end
   end

endmodule

// ==== tb/ccr_regs_properties.sv ====
// Port checker for the configuration register group
`timescale 1ns/1ps
module ccr_regs_properties (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Serial pins and state
   input wire logic csb_pin,
   input wire logic sclk_pin,
   input wire logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic lsb_first,
   input wire logic soft_reset_pulse
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   chk_reset_quiet: assert property ($rose(rst_n) |->
      !sdio_oe && !lsb_first && !soft_reset_pulse) else $error("reset state");
   chk_pulse_single: assert property (
      soft_reset_pulse |=> !soft_reset_pulse) else $error("long pulse");
   chk_reset_order: assert property (
      soft_reset_pulse |-> ##[0:1] !lsb_first) else $error("order kept");
   chk_pulse_quiet: assert property (
      soft_reset_pulse |-> !sdio_oe) else $error("pulse in read");
   chk_oe_idle: assert property (
      csb_pin [*6] |-> !sdio_oe) else $error("drives while idle");
   // Read bits shift only in the low phase
   chk_out_shift: assert property (
      sdio_oe && $past(sdio_oe) && $changed(sdio_out) |-> !$past(sclk_pin))
      else $error("shift on high");
endmodule
bind ccr_regs ccr_regs_properties u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
   .csb_pin(csb_pin), .sclk_pin(sclk_pin), .sdio_in(sdio_in),
   .sdio_out(sdio_out), .sdio_oe(sdio_oe), .lsb_first(lsb_first),
   .soft_reset_pulse(soft_reset_pulse));

// ==== tb/ccr_host.sv ====
// Serial port host model driving the configuration port
`timescale 1ns/1ps
module ccr_host (
   // Clock
   input wire logic clk_sys,
   // Serial pins
   output logic     csb_pin,
   output logic     sclk_pin,
   output logic     sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe
);
   logic host_d = 1'b0;
   logic lsb    = 1'b0;
   initial begin
      csb_pin  = 1'b1;
      sclk_pin = 1'b0;
   end
   // Released line toggles so a stale bit never looks valid
   assign sdio_in = sdio_oe ? sdio_out : host_d;
   // ----------------------------------------
   // Bit and frame tasks
   // ----------------------------------------
   // Low 5, high 4 cycles: well inside the pin sampling limit
   task automatic bit_io(input logic b, output logic r);
      host_d = b;
      repeat (5) @(negedge clk_sys);
      r = sdio_in;
      sclk_pin = 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk_pin = 1'b0;
   endtask
   // One-byte frame in the host's current bit order
   task automatic xfer(input logic rd, input logic [12:0] a,
                       input logic [7:0] w, output logic [7:0] r);
      logic [15:0] ins;
      logic        x;
      ins = {rd, 2'b00, a};
      @(negedge clk_sys);
      csb_pin = 1'b0;
      for (int i = 0; i < 16; i++) bit_io(lsb ? ins[i] : ins[15-i], x);
      for (int i = 0; i < 8; i++) begin
         bit_io(rd ? ~host_d : (lsb ? w[i] : w[7-i]), x);
         if (lsb) r[i] = x;
         else r[7-i] = x;
      end
      repeat (6) @(negedge clk_sys);
      csb_pin = 1'b1;
      repeat (6) @(negedge clk_sys);
   endtask
   // Three-byte read, MSB first only; the address walks down
   task automatic burst_rd(input logic [12:0] a, output logic [23:0] r);
      logic [15:0] ins;
      logic        x;
      ins = {1'b1, 2'b10, a};
      @(negedge clk_sys);
      csb_pin = 1'b0;
      for (int i = 0; i < 16; i++) bit_io(ins[15-i], x);
      for (int i = 0; i < 24; i++) begin
         bit_io(~host_d, x);
         r = {r[22:0], x};
      end
      repeat (6) @(negedge clk_sys);
      csb_pin = 1'b1;
      repeat (6) @(negedge clk_sys);
   endtask
endmodule

// ==== tb/converter_chip_config_regs_test.sv ====
// Testbench for the configuration register group
`timescale 1ns/1ps
`define CCR_CHECK(n, e, s) begin tests_run++; if ((s) !== (e)) begin \
   err_total++; $display("unexpected %s exp %h got %h", n, e, s); end end
module converter_chip_config_regs_test;
   import ccr_pkg::*;
   localparam logic [7:0] ID = 8'h5C;   // Arbitrary value
   localparam logic [23:0] BURST = {8'h20, ID, 8'h18};
   logic [23:0] rd3;
   logic       clk_sys = 1'b0;
   logic       rst_n   = 1'b0;
   logic       csb_pin, sclk_pin, sdio_in, sdio_out, sdio_oe;
   logic       lsb_first, soft_reset_pulse;
   logic       saw_pulse = 1'b0;
   logic [7:0] rd;
   int         err_total = 0;
   int         tests_run = 0;
   int         cyc = 0;
   always #25 clk_sys = ~clk_sys;
   ccr_regs #(.CHIP_IDENTIFIER_CODE(ID), .SPEED_GRADE(GRADE_65MSPS)) dut (
      .clk_sys(clk_sys), .rst_n(rst_n), .csb_pin(csb_pin),
      .sclk_pin(sclk_pin), .sdio_in(sdio_in), .sdio_out(sdio_out),
      .sdio_oe(sdio_oe), .lsb_first(lsb_first),
      .soft_reset_pulse(soft_reset_pulse));
   ccr_host host (.clk_sys(clk_sys), .csb_pin(csb_pin), .sclk_pin(sclk_pin),
      .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task finish_test;
      $display("errors %0d checks %0d", err_total, tests_run);
      if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task rd_chk(input string n, input logic [12:0] a, input logic [7:0] e);
      host.xfer(1'b1, a, 8'h00, rd);
      `CCR_CHECK(n, e, rd)
   endtask
   task wr(input logic [12:0] a, input logic [7:0] w);
      host.xfer(1'b0, a, w, rd);
   endtask
   // One-byte frames take about 230 cycles, the burst about 373; ceiling leaves wide margin
   always @(posedge clk_sys) begin
      cyc++;
      if (soft_reset_pulse === 1'b1) saw_pulse <= 1'b1;
      if (cyc > 10000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      rd_chk("cfg", 13'h0000, 8'h18);
      rd_chk("id", 13'h0001, ID);
      rd_chk("grade", 13'h0002, 8'h20);
      rd_chk("open", 13'h0005, 8'h00);
      host.burst_rd(13'h0002, rd3);
      `CCR_CHECK("burst", BURST, rd3)
      wr(13'h0001, 8'hFF);
      wr(13'h0002, 8'hFF);
      rd_chk("id_ro", 13'h0001, ID);
      rd_chk("grade_ro", 13'h0002, 8'h20);
      wr(13'h0000, 8'h42);
      `CCR_CHECK("lsb_first", 1'b1, lsb_first)
      `CCR_CHECK("no_pulse", 1'b0, saw_pulse)
      host.lsb = 1'b1;
      rd_chk("cfg_lsb", 13'h0000, 8'h5A);
      wr(13'h0000, 8'h24);
      `CCR_CHECK("srst_pulse", 1'b1, saw_pulse)
      `CCR_CHECK("lsb_clr", 1'b0, lsb_first)
      host.lsb = 1'b0;
      rd_chk("cfg_dflt", 13'h0000, 8'h18);
      wr(13'h0000, 8'h42);
      @(negedge clk_sys);
      rst_n = 1'b0;
      repeat (2) @(negedge clk_sys);
      rst_n = 1'b1;
      `CCR_CHECK("rst_order", 1'b0, lsb_first)
      rd_chk("cfg_rst", 13'h0000, 8'h18);
      finish_test();
   end
endmodule
